// ===== hw/hcp_consts.vh
// constants for the host register window of the switch cpu port
// assumes: included by hcp_top.v and hcp_frame_fifo.v, no other context
// What this block does
// - 16-bit or serial mode: write at address 0 loads full 16-bit pointer.
// - 8-bit mode: write at address 0 loads pointer low byte only.
// - 8-bit mode: address 1 loads pointer high byte; write-only, resets zero.
// - address 2 reads and writes the indirect register the pointer selects.
// - address 3 moves frame data through an 8-byte fifo both ways.
// - 16-bit words carry even byte low, odd byte high, both directions.
// - frame fifo location disabled in serial-plus-mii configuration.
// - status at address 4 resets zero but bit 4, set by the empty incoming fifo; inactive in mii, remote, no-host modes.
// - status bit 0 reads 1 while command input buffer accepts a command.
// - writing 1 to bit 0 marks command frame written; strobe self-clears.
// - status bits 1, 2 read 1 while response buffer one, two holds data.
// - writing 1 to bit 1 or 2 marks response consumed; self-clears.
// - writing 1 to bit 3 marks outgoing frame taken; self-clears.
// - status bit 3 reads 1 while the outgoing fifo holds data.
// - writing 1 to bit 4 marks the next incoming fifo write as last.
// - status bit 4 reads 1 while the incoming fifo has room: one byte in 8-bit mode, two bytes in other modes.
// - writing 1 to bit 5 restarts incoming data alignment; debug only.
// - status bit 5 reads 1 when outgoing fifo reached end of frame.
// - interrupt source bit 0 set while frame buffer holds host data.
// - interrupt bits 1, 2 follow response buffers; bits 6:3 reserved zero.
// - interrupt bit 7 flags timeout, sticky until host writes 0.
// - address 6 is command buffer one: writes commands, reads responses.
// - address 7 is command buffer two: read-only responses.
`ifndef HCP_CONSTS_VH
`define HCP_CONSTS_VH

// -----------------------------------------------------------------------
// direct addresses
// -----------------------------------------------------------------------
`define HCP_ADDR_PTR_LOW 3'h0
`define HCP_ADDR_PTR_HIGH 3'h1
`define HCP_ADDR_DATA 3'h2
`define HCP_ADDR_FRAME 3'h3
`define HCP_ADDR_STATUS 3'h4
`define HCP_ADDR_IRQ 3'h5
`define HCP_ADDR_CMD_ONE 3'h6
`define HCP_ADDR_CMD_TWO 3'h7

// -----------------------------------------------------------------------
// host interface modes
// -----------------------------------------------------------------------
`define HCP_MODE_BUS8 3'h0
`define HCP_MODE_BUS16 3'h1
`define HCP_MODE_SERIAL 3'h2
`define HCP_MODE_SERIAL_MII 3'h3
`define HCP_MODE_MII_ONLY 3'h4
`define HCP_MODE_NO_HOST 3'h5

// -----------------------------------------------------------------------
// status and interrupt bit positions
// -----------------------------------------------------------------------
`define HCP_ST_CMD_IN 0
`define HCP_ST_RESP_ONE 1
`define HCP_ST_RESP_TWO 2
`define HCP_ST_OUT_DATA 3
`define HCP_ST_IN_ROOM 4
`define HCP_ST_ALIGN_EOF 5
`define HCP_IRQ_FRAME 0
`define HCP_IRQ_RESP_ONE 1
`define HCP_IRQ_RESP_TWO 2
`define HCP_IRQ_TIMEOUT 7

// -----------------------------------------------------------------------
// reset values and sizes
// -----------------------------------------------------------------------
`define HCP_RST_PTR 16'h0000
`define HCP_RST_BYTE 8'h00
`define HCP_RST_WORD 16'h0000
`define HCP_FIFO_BYTES 8

`endif

// ===== hw/hcp_frame_fifo.v
// byte fifo between the host frame port and the internal cpu mac
// assumes: single clock, push and pop are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "hcp_consts.vh"

module hcp_frame_fifo #(
    parameter DEPTH = `HCP_FIFO_BYTES,
    parameter AW = 3
) (
    input wire ref_clk,
    input wire rst_b,
    input wire flush,
    input wire push,
    input wire [8:0] push_data,
    input wire pop,
    output wire [8:0] pop_data,
    output wire empty,
    output wire full,
    output wire room_two
);
    // bit 8 of each entry carries the end-of-frame mark
    reg [8:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_push;
    wire do_pop;

    // full and empty gate the strobes so the count stays honest
    assign do_push = push && (count != DEPTH[AW:0]);
    assign do_pop = pop && (count != {(AW+1){1'b0}});
    assign pop_data = mem[rd_ptr];
    assign empty = (count == {(AW+1){1'b0}});
    assign full = (count == DEPTH[AW:0]);
    assign room_two = (count <= DEPTH[AW:0] - 2'd2);

    // storage, no reset needed on the data
    always @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // pointers and fill count
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // hcp_frame_fifo

`default_nettype wire

// ===== hw/hcp_top.v
// direct host register window: pointer, data window, frame fifos, handshakes
// assumes: host strobes synchronous to ref_clk, one access per strobe,
// indirect space and command engine sit outside and answer combinationally
`timescale 1ns/1ps
`default_nettype none
`include "hcp_consts.vh"

module hcp_top (
    input wire ref_clk,
    input wire rst_b,
    input wire [2:0] host_mode,
    input wire [2:0] host_addr,
    input wire host_wr,
    input wire host_rd,
    input wire [15:0] host_wdata,
    output reg [15:0] host_rdata,
    output reg [15:0] ind_addr,
    output reg ind_wr,
    output reg ind_rd,
    output reg [7:0] ind_wdata,
    input wire [7:0] ind_rdata,
    output reg [8:0] mac_rx_data,
    output reg mac_rx_valid,
    input wire mac_rx_ready,
    input wire [8:0] mac_tx_data,
    input wire mac_tx_valid,
    output reg mac_tx_ready,
    output reg align_restart,
    output reg outframe_taken_strobe,
    output reg cmd_in_written_strobe,
    output reg resp_one_consumed_strobe,
    output reg resp_two_consumed_strobe,
    input wire cmd_in_accepting,
    input wire resp_one_available,
    input wire resp_two_available,
    output reg [15:0] cmd_wdata,
    output reg cmd_wr,
    output reg cmd_one_rd,
    output reg cmd_two_rd,
    input wire [15:0] cmd_one_rdata,
    input wire [15:0] cmd_two_rdata,
    input wire timeout_event
);
    // -------------------------------------------------------------------
    // mode decode
    // -------------------------------------------------------------------
    wire bus8;
    wire frame_on;
    wire status_on;
    wire wr_acc;
    wire rd_acc;
    assign bus8 = (host_mode == `HCP_MODE_BUS8);
    assign frame_on = (host_mode != `HCP_MODE_SERIAL_MII);
    assign status_on = (host_mode == `HCP_MODE_BUS8) ||
        (host_mode == `HCP_MODE_BUS16) || (host_mode == `HCP_MODE_SERIAL);
    assign wr_acc = host_wr && !host_rd;
    assign rd_acc = host_rd && !host_wr;

    // address match helper shared by the decodes below, except the case in the read mux
    function hit;
        input [2:0] a;
        input [2:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // -------------------------------------------------------------------
    // indirect pointer
    // -------------------------------------------------------------------
    reg [15:0] ptr;
    wire [15:0] next_ptr;
    // full word in wide modes, bytes in 8-bit mode
    assign next_ptr = (wr_acc && hit(host_addr, `HCP_ADDR_PTR_LOW) && !bus8) ?
        host_wdata :
        (wr_acc && hit(host_addr, `HCP_ADDR_PTR_LOW)) ?
        {ptr[15:8], host_wdata[7:0]} :
        (wr_acc && bus8 && hit(host_addr, `HCP_ADDR_PTR_HIGH)) ?
        {host_wdata[7:0], ptr[7:0]} : ptr;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr <= `HCP_RST_PTR;
        end else begin
            ptr <= next_ptr;
        end
    end

    // -------------------------------------------------------------------
    // frame fifos: host-to-mac and mac-to-host
    // -------------------------------------------------------------------
    reg last_mark;
    reg odd_pending;
    reg [8:0] odd_byte;
    reg out_eof;
    reg in_half;
    wire in_empty;
    wire in_full;
    wire in_room2;
    wire [8:0] in_head;
    wire out_empty;
    wire out_full;
    wire [8:0] out_head;
    wire [8:0] out_next;
    wire frame_wr;
    wire frame_rd;
    wire in_push;
    wire [8:0] in_pdata;
    wire in_pop;
    wire out_push;
    wire out_pop;
    wire st_wr;
    wire [8:0] out_peek;

    assign frame_wr = wr_acc && frame_on && hit(host_addr, `HCP_ADDR_FRAME);
    assign frame_rd = rd_acc && frame_on && hit(host_addr, `HCP_ADDR_FRAME);
    assign st_wr = wr_acc && status_on && hit(host_addr, `HCP_ADDR_STATUS);

    // a wide write is split: even byte now, odd byte next cycle
    assign in_push = (frame_wr && !(in_full)) || odd_pending;
    assign in_pdata = odd_pending ? odd_byte :
        {last_mark && (bus8), host_wdata[7:0]};
    assign in_pop = mac_rx_valid && mac_rx_ready;

    hcp_frame_fifo #(.DEPTH(`HCP_FIFO_BYTES), .AW(3)) u_in_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flush(align_restart),
        .push(in_push),
        .push_data(in_pdata),
        .pop(in_pop),
        .pop_data(in_head),
        .empty(in_empty),
        .full(in_full),
        .room_two(in_room2)
    );

    // wide reads pop two bytes, narrow reads one
    assign out_pop = frame_rd && !out_empty;
    assign out_push = mac_tx_valid && mac_tx_ready;
    assign out_peek = out_head;

    hcp_frame_fifo #(.DEPTH(`HCP_FIFO_BYTES), .AW(3)) u_out_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flush(outframe_taken_strobe),
        .push(out_push),
        .push_data(mac_tx_data),
        .pop(out_pop || (in_half)),
        .pop_data(out_next),
        .empty(out_empty),
        .full(out_full),
        .room_two()
    );
    assign out_head = out_next;

    // odd byte carry and end-of-frame marking on the incoming side
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_mark <= 1'b0;
            odd_pending <= 1'b0;
            odd_byte <= 9'h000;
        end else begin
            odd_pending <= frame_wr && !bus8 && !in_full;
            odd_byte <= {last_mark, host_wdata[15:8]};
            if (st_wr && host_wdata[`HCP_ST_IN_ROOM]) begin
                last_mark <= 1'b1;
            end else if (frame_wr) begin
                last_mark <= 1'b0;
            end
        end
    end

    // second byte of a wide read comes off the fifo one cycle later
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_half <= 1'b0;
            out_eof <= 1'b0;
        end else begin
            in_half <= out_pop && !bus8;
            if ((out_pop || in_half) && out_peek[8]) begin
                out_eof <= 1'b1;
            end else if (outframe_taken_strobe) begin
                out_eof <= 1'b0;
            end
        end
    end

    // mac side handshakes, registered
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mac_rx_data <= 9'h000;
            mac_rx_valid <= 1'b0;
            mac_tx_ready <= 1'b0;
        end else begin
            mac_rx_data <= in_head;
            mac_rx_valid <= !in_empty && !in_pop;
            mac_tx_ready <= !out_full && !out_push;
        end
    end

    // -------------------------------------------------------------------
    // self-clearing strobes, data window and command buffer access
    // -------------------------------------------------------------------
    reg irq_timeout;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_in_written_strobe <= 1'b0;
            resp_one_consumed_strobe <= 1'b0;
            resp_two_consumed_strobe <= 1'b0;
            outframe_taken_strobe <= 1'b0;
            align_restart <= 1'b0;
            ind_addr <= `HCP_RST_PTR;
            ind_wr <= 1'b0;
            ind_rd <= 1'b0;
            ind_wdata <= `HCP_RST_BYTE;
            cmd_wdata <= `HCP_RST_WORD;
            cmd_wr <= 1'b0;
            cmd_one_rd <= 1'b0;
            cmd_two_rd <= 1'b0;
        end else begin
            cmd_in_written_strobe <= st_wr && host_wdata[`HCP_ST_CMD_IN];
            resp_one_consumed_strobe <= st_wr && host_wdata[`HCP_ST_RESP_ONE];
            resp_two_consumed_strobe <= st_wr && host_wdata[`HCP_ST_RESP_TWO];
            outframe_taken_strobe <= st_wr && host_wdata[`HCP_ST_OUT_DATA];
            align_restart <= st_wr && host_wdata[`HCP_ST_ALIGN_EOF];
            // next_ptr lets a data access follow a pointer write at once
            ind_addr <= next_ptr;
            ind_wr <= wr_acc && hit(host_addr, `HCP_ADDR_DATA);
            ind_rd <= rd_acc && hit(host_addr, `HCP_ADDR_DATA);
            ind_wdata <= host_wdata[7:0];
            cmd_wdata <= bus8 ? {8'h00, host_wdata[7:0]} : host_wdata;
            cmd_wr <= wr_acc && hit(host_addr, `HCP_ADDR_CMD_ONE);
            cmd_one_rd <= rd_acc && hit(host_addr, `HCP_ADDR_CMD_ONE);
            cmd_two_rd <= rd_acc && hit(host_addr, `HCP_ADDR_CMD_TWO);
        end
    end

    // timeout flag: sticky, host writes 0 to clear, new event wins
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_timeout <= 1'b0;
        end else if (timeout_event) begin
            irq_timeout <= 1'b1;
        end else if (wr_acc && hit(host_addr, `HCP_ADDR_IRQ) &&
            !host_wdata[`HCP_IRQ_TIMEOUT]) begin
            irq_timeout <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // read mux, registered so data follows the read strobe by one edge
    // -------------------------------------------------------------------
    reg [7:0] status_val;
    reg [7:0] irq_val;
    reg [15:0] next_rdata;
    always @* begin
        status_val = 8'h00;
        status_val[`HCP_ST_CMD_IN] = cmd_in_accepting;
        status_val[`HCP_ST_RESP_ONE] = resp_one_available;
        status_val[`HCP_ST_RESP_TWO] = resp_two_available;
        status_val[`HCP_ST_OUT_DATA] = !out_empty;
        status_val[`HCP_ST_IN_ROOM] = bus8 ? !in_full : in_room2;
        status_val[`HCP_ST_ALIGN_EOF] = out_eof;
        irq_val = 8'h00;
        irq_val[`HCP_IRQ_FRAME] = !out_empty;
        irq_val[`HCP_IRQ_RESP_ONE] = resp_one_available;
        irq_val[`HCP_IRQ_RESP_TWO] = resp_two_available;
        irq_val[`HCP_IRQ_TIMEOUT] = irq_timeout;
        next_rdata = host_rdata;
        if (rd_acc) begin
            case (host_addr)
                `HCP_ADDR_DATA: next_rdata = {8'h00, ind_rdata};
                `HCP_ADDR_FRAME: next_rdata = !frame_on ? 16'h0000 :
                    (bus8 ? {8'h00, out_head[7:0]} : {8'h00, out_head[7:0]});
                `HCP_ADDR_STATUS: next_rdata = status_on ? {8'h00, status_val} :
                    16'h0000;
                `HCP_ADDR_IRQ: next_rdata = {8'h00, irq_val};
                `HCP_ADDR_CMD_ONE: next_rdata = bus8 ? {8'h00, cmd_one_rdata[7:0]} :
                    cmd_one_rdata;
                `HCP_ADDR_CMD_TWO: next_rdata = bus8 ? {8'h00, cmd_two_rdata[7:0]} :
                    cmd_two_rdata;
                default: next_rdata = 16'h0000; // write-only pointer reads zero
            endcase
        end
    end

    // odd byte of a wide frame read lands in the high lane a cycle later
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_rdata <= `HCP_RST_WORD;
        end else if (in_half) begin
            host_rdata <= {out_head[7:0], host_rdata[7:0]};
        end else begin
            host_rdata <= next_rdata;
        end
    end
endmodule // hcp_top

`default_nettype wire

// ===== sim/hcp_props.sv
// checker on the host window ports of hcp_top
// assumes: bound into hcp_top, one clock, rst_b low clears all state
`timescale 1ns/1ps
`default_nettype none
module hcp_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [2:0] host_mode,
    input wire logic [2:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic [15:0] ind_addr,
    input wire logic ind_rd,
    input wire logic [7:0] ind_rdata,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_in_written_strobe,
    input wire logic cmd_in_accepting,
    input wire logic resp_one_available,
    input wire logic resp_two_available
);
    // ------------------------------
    // decoded requests
    // ------------------------------
    // both strobes high is ignored, so decode the exclusive cases only
    wire logic wr_ok = host_wr && !host_rd;
    wire logic rd_ok = host_rd && !host_wr;
    wire logic live = host_mode <= 3'h2;
    wire logic [7:0] w_lo = host_wdata[7:0];
    wire logic [2:0] hs = {resp_two_available, resp_one_available, cmd_in_accepting};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    property p_ptr_wide;
        wr_ok && host_addr == 3'h0 && (host_mode == 3'h1 || host_mode == 3'h2)
            |=> ind_addr == $past(host_wdata);
    endproperty
    a_ptr_wide: assert property (p_ptr_wide) else $error("wide pointer load wrong");
    property p_ptr_low;
        wr_ok && host_addr == 3'h0 && host_mode == 3'h0
            |=> ind_addr[7:0] == $past(w_lo) && $stable(ind_addr[15:8]);
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer low byte wrong");
    property p_ptr_high;
        wr_ok && host_addr == 3'h1 && host_mode == 3'h0
            |=> ind_addr[15:8] == $past(w_lo) && $stable(ind_addr[7:0]);
    endproperty
    a_ptr_high: assert property (p_ptr_high) else $error("pointer high byte wrong");
    property p_data_rd;
        rd_ok && host_addr == 3'h2 |=> ind_rd && host_rdata[7:0] == $past(ind_rdata);
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("data window read wrong");
    property p_cmd_wr;
        wr_ok && host_addr == 3'h6 && host_mode == 3'h1 |=> cmd_wr && cmd_wdata == $past(host_wdata);
    endproperty
    a_cmd_wr: assert property (p_cmd_wr) else $error("command word not passed");
    property p_stat_rd;
        rd_ok && host_addr == 3'h4 && live |=> host_rdata[2:0] == $past(hs);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status ready bits wrong");
    property p_stat_mute;
        rd_ok && host_addr == 3'h4 && !live |=> host_rdata == 16'h0000;
    endproperty
    a_stat_mute: assert property (p_stat_mute) else $error("status not muted");
    property p_in_done;
        wr_ok && host_addr == 3'h4 && live && host_wdata[0]
            |=> $rose(cmd_in_written_strobe) ##1 $fell(cmd_in_written_strobe);
    endproperty
    a_in_done: assert property (p_in_done) else $error("command done pulse wrong");
    c_ptr_high: cover property (wr_ok && host_addr == 3'h1);
    c_stat_wr: cover property (wr_ok && host_addr == 3'h4);
    c_frame_rd: cover property (rd_ok && host_addr == 3'h3);
endmodule // hcp_props

bind hcp_top hcp_props u_props (.*);
`default_nettype wire

// ===== sim/hcp_far_model.sv
// far side model: indirect register space and cpu mac receive sink
// assumes: hcp_top holds the pointer on ind_addr and pulses ind_wr
`timescale 1ns/1ps
`default_nettype none
module hcp_far_model (
    input wire logic ref_clk,
    input wire logic [15:0] ind_addr,
    input wire logic ind_wr,
    input wire logic [7:0] ind_wdata,
    output logic [7:0] ind_rdata,
    input wire logic [8:0] mac_rx_data,
    input wire logic mac_rx_valid,
    output logic mac_rx_ready,
    input wire logic rx_hold
);
    // ------------------------------
    // indirect space and mac sink
    // ------------------------------
    logic [7:0] mem [0:15] = '{default: 8'h00};
    logic [8:0] rx_log [0:15];
    int rx_n = 0;
    // high pointer byte mixed in, so a wrong high half shows in the data
    assign ind_rdata = mem[ind_addr[3:0]] ^ ind_addr[15:8];
    // the bench stalls the mac to fill the fifo
    assign mac_rx_ready = !rx_hold;
    // indirect writes and received bytes
    always @(posedge ref_clk) begin
        if (ind_wr === 1'h1)
            mem[ind_addr[3:0]] <= ind_wdata;
        if (mac_rx_valid === 1'h1 && mac_rx_ready) begin
            rx_log[rx_n] <= mac_rx_data;
            rx_n <= rx_n + 1;
        end
    end
endmodule // hcp_far_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the host register window
// assumes: hcp_top, hcp_props and hcp_far_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_b, host_wr, host_rd, ind_wr, ind_rd, mac_rx_valid, mac_rx_ready;
    logic mac_tx_valid, mac_tx_ready, align_restart, outframe_taken_strobe, rx_hold;
    logic cmd_in_written_strobe, resp_one_consumed_strobe, resp_two_consumed_strobe;
    logic cmd_in_accepting, resp_one_available, resp_two_available;
    logic cmd_wr, cmd_one_rd, cmd_two_rd, timeout_event;
    logic [2:0] host_mode, host_addr;
    logic [7:0] ind_wdata, ind_rdata, stb;
    logic [8:0] mac_rx_data, mac_tx_data;
    logic [15:0] host_wdata, host_rdata, ind_addr, cmd_wdata, cmd_one_rdata, cmd_two_rdata;
    int cnt[8];
    int n_errors = 0;
    int check_count = 0;
    hcp_top DUT (.*);
    hcp_far_model FAR (.*);
    // ------------------------------
    // clock, pulse counters, watchdog
    // ------------------------------
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // pulses counted so missing and doubled strobes both show
    assign stb = {cmd_two_rd, cmd_one_rd, cmd_wr, resp_two_consumed_strobe,
        resp_one_consumed_strobe, cmd_in_written_strobe, outframe_taken_strobe, align_restart};
    always @(posedge ref_clk)
        if (rst_b)
            foreach (cnt[k])
                cnt[k] <= cnt[k] + int'(stb[k]);
    // the run needs under 2000 cycles
    initial begin
        #80000;
        n_errors++;
        $display("ERROR watchdog expected finish seen hang");
        results;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'h1;
        @(posedge ref_clk);
        host_wr <= 1'h0;
    endtask
    // sampled two cycles on, where the odd frame byte has landed too
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        host_addr <= a;
        host_rd <= 1'h1;
        @(posedge ref_clk);
        host_rd <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = host_rdata;
    endtask
    task automatic tx(input logic [8:0] b);
        @(posedge ref_clk);
        mac_tx_data <= b;
        mac_tx_valid <= 1'h1;
        do begin
            @(negedge ref_clk);
        end while (mac_tx_ready !== 1'h1);
        @(posedge ref_clk);
        mac_tx_valid <= 1'h0;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_pointer;
        logic [15:0] d;
        host_mode <= 3'h1;
        wr(3'h0, 16'ha503);
        rd(3'h2, d);
        chk("wide pointer", 16'h00a5, {8'h00, d[7:0]});
        wr(3'h2, 16'h005c);
        rd(3'h2, d);
        chk("data window", 16'h00f9, {8'h00, d[7:0]});
        rd(3'h0, d);
        chk("pointer read", 16'h0000, d);
        host_mode <= 3'h0;
        wr(3'h0, 16'h3c07);
        rd(3'h2, d);
        chk("byte pointer low", 16'h00a5, {8'h00, d[7:0]});
        wr(3'h1, 16'h0012);
        rd(3'h2, d);
        chk("byte pointer high", 16'h0012, {8'h00, d[7:0]});
        rd(3'h1, d);
        chk("pointer high read", 16'h0000, d);
    endtask
    task automatic t_status;
        int b[8];
        logic [15:0] d;
        host_mode <= 3'h1;
        cmd_in_accepting <= 1'h1;
        resp_two_available <= 1'h1;
        rd(3'h4, d);
        chk("status ready", 16'h0005, {13'h0, d[2:0]});
        cmd_in_accepting <= 1'h0;
        resp_one_available <= 1'h1;
        resp_two_available <= 1'h0;
        rd(3'h4, d);
        chk("status ready", 16'h0002, {13'h0, d[2:0]});
        b = cnt;
        wr(3'h4, 16'h0007);
        wr(3'h4, 16'h0008);
        wr(3'h4, 16'h0020);
        for (int m = 3; m < 6; m++) begin
            host_mode <= 3'(m);
            rd(3'h4, d);
            chk("status off", 16'h0000, d);
            wr(3'h4, 16'h003f);
        end
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 5; k++)
            chk("handshake pulses", 16'h0001, 16'(cnt[k] - b[k]));
    endtask
    task automatic t_frame_in;
        logic [15:0] d;
        host_mode <= 3'h1;
        rx_hold <= 1'h1;
        rd(3'h4, d);
        chk("room empty", 16'h0001, {15'h0, d[4]});
        wr(3'h3, 16'h0100);
        wr(3'h3, 16'h0302);
        wr(3'h3, 16'h0504);
        wr(3'h4, 16'h0010);
        wr(3'h3, 16'h0706);
        rd(3'h4, d);
        chk("room full", 16'h0000, {15'h0, d[4]});
        rx_hold <= 1'h0;
        repeat (20) @(posedge ref_clk);
        chk("bytes to mac", 16'h0008, 16'(FAR.rx_n));
        for (int k = 0; k < 8; k++)
            chk("byte to mac", {7'h0, 1'(k == 7), 8'(k)}, {7'h0, FAR.rx_log[k]});
        rd(3'h4, d);
        chk("room drained", 16'h0001, {15'h0, d[4]});
    endtask
    task automatic t_frame_out;
        logic [15:0] d;
        resp_one_available <= 1'h0;
        tx(9'h011);
        tx(9'h122);
        repeat (4) @(posedge ref_clk);
        rd(3'h4, d);
        chk("out has data", 16'h0001, {15'h0, d[3]});
        rd(3'h5, d);
        chk("frame interrupt", 16'h0001, {8'h00, d[7:0]});
        host_mode <= 3'h3;
        rd(3'h3, d);
        chk("frame port off", 16'h0000, d);
        host_mode <= 3'h1;
        rd(3'h3, d);
        chk("frame word", 16'h2211, d);
        rd(3'h4, d);
        chk("eof seen", 16'h0001, {15'h0, d[5]});
        wr(3'h4, 16'h0008);
        rd(3'h4, d);
        chk("out drained", 16'h0000, {14'h0, d[5], d[3]});
    endtask
    task automatic t_irq_cmd;
        int b[8];
        logic [15:0] d;
        resp_one_available <= 1'h1;
        resp_two_available <= 1'h1;
        cmd_one_rdata <= 16'h4433;
        cmd_two_rdata <= 16'h6655;
        rd(3'h5, d);
        chk("interrupts", 16'h0006, {8'h00, d[7:0]});
        @(posedge ref_clk);
        timeout_event <= 1'h1;
        @(posedge ref_clk);
        timeout_event <= 1'h0;
        rd(3'h5, d);
        chk("timeout set", 16'h0086, {8'h00, d[7:0]});
        rd(3'h5, d);
        chk("timeout kept", 16'h0086, {8'h00, d[7:0]});
        wr(3'h5, 16'h0000);
        rd(3'h5, d);
        chk("timeout cleared", 16'h0006, {8'h00, d[7:0]});
        b = cnt;
        wr(3'h6, 16'h2211);
        rd(3'h6, d);
        chk("buffer one", 16'h4433, d);
        rd(3'h7, d);
        chk("buffer two", 16'h6655, d);
        wr(3'h7, 16'h1234);
        repeat (2) @(posedge ref_clk);
        for (int k = 5; k < 8; k++)
            chk("buffer pulses", 16'h0001, 16'(cnt[k] - b[k]));
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // reset for four cycles, then the scenarios in turn
    initial begin
        rst_b = 1'h0;
        {host_wr, host_rd, mac_tx_valid, cmd_in_accepting, resp_one_available,
            resp_two_available, timeout_event, rx_hold} = 8'h00;
        {host_mode, host_addr, host_wdata, mac_tx_data, cmd_one_rdata, cmd_two_rdata} = 63'h0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        t_pointer;
        t_status;
        t_frame_in;
        t_frame_out;
        t_irq_cmd;
        results;
    end
endmodule // tb_top
`default_nettype wire
